// file: eeprom_autoload_pkg.sv
`default_nettype none
package eeprom_autoload_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int ADDR_W = 6;
   typedef logic [WORD_W-1:0] word_t;
   typedef logic [ADDR_W-1:0] addr_t;

   // ----------------------------------------------------------------
   // word indices in the configuration memory
   // ----------------------------------------------------------------
   localparam addr_t W_MAC_FIRST  = 6'h00;
   localparam addr_t W_MAC_LAST   = 6'h02;
   localparam addr_t W_AUTO_CTL   = 6'h03;
   localparam addr_t W_VENDOR     = 6'h04;
   localparam addr_t W_PRODUCT    = 6'h05;
   localparam addr_t W_PIN_CTL    = 6'h06;
   localparam addr_t W_PHY_CTL    = 6'h07;
   localparam addr_t W_MISC       = 6'h08;
   localparam addr_t W_GRP_CTL    = 6'h10;
   localparam addr_t W_SWITCH     = 6'h11;
   localparam addr_t W_PORT_FIRST = 6'h13;
   localparam addr_t W_PORT_LAST  = 6'h1A;
   localparam addr_t W_TAG_FIRST  = 6'h1B;
   localparam addr_t W_TAG_LAST   = 6'h1E;
   localparam addr_t W_PRIO       = 6'h1F;

   // ----------------------------------------------------------------
   // two-bit enable fields: position of their low bit
   // ----------------------------------------------------------------
   localparam logic [1:0] FIELD_ON  = 2'h1;
   localparam int AC_ID_LSB    = 0;
   localparam int AC_PIN_LSB   = 2;
   localparam int AC_WAKE_LSB  = 6;
   localparam int AC_MISC_LSB  = 8;
   localparam int AC_LED_LSB   = 10;
   localparam int AC_MDIX_LSB  = 14;
   localparam int GC_SW_LSB    = 0;
   localparam int GC_PORT_LSB  = 2;
   localparam int GC_TAG_LSB   = 4;
   localparam int GC_PRIO_LSB  = 6;

   // ----------------------------------------------------------------
   // loaded settings
   // ----------------------------------------------------------------
   typedef struct packed {
      logic irq_open;   // 1: open collector
      logic irq_low;    // 1: interrupt active low
      logic wr_high;    // write_strobe_pin active high
      logic rd_high;    // read_strobe_pin active high
      logic cs_high;    // chip select active high
   } host_pin_s;

   typedef struct packed {
      logic       mdix_p0;    // automatic_crossover port 0
      logic       mdix_p1;    // automatic_crossover port 1
      logic       led_alt;
      logic [3:0] wake;       // link, magic, pulse, low
   } phy_ctl_s;

   typedef struct packed {
      logic [7:0] ctl_61;
      logic [7:0] ctl_66;
      logic [7:0] ctl_67;
      logic [7:0] ctl_6d;
      logic [7:0] tag_6e;
      logic [7:0] tag_6f;
   } port_regs_s;

   typedef struct packed {
      logic [47:0]     mac;       // byte 0 in bits 7:0
      word_t           vendor_id;
      word_t           product_id;
      host_pin_s       pin;
      phy_ctl_s        phy;
      logic [4:0]      misc;
      logic [7:0]      sw_ctl;    // register 52H
      logic [7:0]      vlan_ctl;  // register 53H
      port_regs_s [3:0] port;
      logic [7:0]      prio_lo;   // register D0H
      logic [7:0]      prio_hi;   // register D1H
   } cfg_s;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [47:0] RST_MAC  = 48'h0000_0000_0000;
   localparam host_pin_s   RST_PIN  = 5'h00;
   localparam phy_ctl_s    RST_PHY  = 7'h60;
   localparam logic [4:0]  RST_MISC = 5'h00;
   localparam logic [7:0]  RST_BYTE = 8'h00;

endpackage : eeprom_autoload_pkg
`default_nettype wire

// file: eeprom_word_fetch.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_word_fetch
   import eeprom_autoload_pkg::*;
(
   // clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   // request from the loader
   input  wire logic  i_start,
   input  wire addr_t i_addr,
   output logic       o_done,
   output word_t      o_data,
   // word port towards the memory reader
   output logic       o_mem_req,
   output addr_t      o_mem_addr,
   input  wire logic  i_mem_ack,
   input  wire word_t i_mem_data
);

   // ----------------------------------------------------------------
   // request held until the word comes back
   // ----------------------------------------------------------------
   logic  req_r,  req_nxt;
   addr_t addr_r, addr_nxt;
   logic  done_r, done_nxt;
   word_t data_r, data_nxt;

   // next values: a start while busy is ignored
   always_comb begin
      req_nxt  = req_r;
      addr_nxt = addr_r;
      done_nxt = 1'b0;
      data_nxt = data_r;
      if (req_r) begin
         if (i_mem_ack) begin
            req_nxt  = 1'b0;
            done_nxt = 1'b1;
            data_nxt = i_mem_data;
         end
      end else if (i_start) begin
         req_nxt  = 1'b1;
         addr_nxt = i_addr;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         req_r  <= 1'b0;
         addr_r <= 6'h00;
         done_r <= 1'b0;
         data_r <= 16'h0000;
      end else begin
         req_r  <= req_nxt;
         addr_r <= addr_nxt;
         done_r <= done_nxt;
         data_r <= data_nxt;
      end
   end

   assign o_mem_req  = req_r;
   assign o_mem_addr = addr_r;
   assign o_done     = done_r;
   assign o_data     = data_r;

endmodule : eeprom_word_fetch
`default_nettype wire

// file: eeprom_autoload_config.sv
//
// Contract
// [R1] station address bytes come from words 0 to 2
// [R2] words 4 and 5 accepted only when word 3 bits 1:0 are 01
// [R3] word 6 bits 4:0 applied only when word 3 bits 3:2 are 01
// [R4] word 3 fields 7:6, 11:10, 15:14 gate word 7 bit groups
// [R5] word 8 bits 4:0 accepted only when word 3 bits 9:8 are 01
// [R6] words 4 and 5 replace built-in vendor and product codes
// [R7] word 6 bits 0..2 set chip select and strobe polarities
// [R8] word 6 bit 3 selects interrupt polarity, 1 means active low
// [R9] word 6 bit 4 selects open-collector interrupt drive
// [R10] word 7 bit 0 sets wake output polarity
// [R11] word 7 bit 1 selects pulse or level wake output
// [R12] word 7 bits 2 and 3 enable magic and link wake events
// [R13] word 7 bit 8 selects alternate LED mode
// [R14] memory keeps word 7 bits 13:9 at zero
// [R15] word 7 bits 14 and 15 control crossover, default on
// [R16] word 16 two-bit fields of 01 enable word groups
// [R17] memory keeps word 16 bits 15:14 at zero
// [R18] word 17 bytes load switch and VLAN control registers
// [R19] memory keeps word 18 at zero when group enabled
// [R20] words 19,21,23,25 load port registers 61H and 66H
// [R21] words 20,22,24,26 load port registers 67H and 6DH
// [R22] words 27 to 29 load port 0..2 tag registers
// [R23] word 30 loads processor port tag registers
// [R24] word 31 loads priority map registers
// [R25] any field other than 01 leaves defaults untouched
`timescale 1ns/1ns
`default_nettype none
module eeprom_autoload_config
   import eeprom_autoload_pkg::*;
#(
   parameter logic [15:0] DEF_VENDOR_ID  = 16'h1234, // arbitrary value
   parameter logic [15:0] DEF_PRODUCT_ID = 16'h5678  // arbitrary value
)(
   // clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   // word port towards the memory reader
   output logic       o_mem_req,
   output addr_t      o_mem_addr,
   input  wire logic  i_mem_ack,
   input  wire word_t i_mem_data,
   // loaded configuration
   output cfg_s       o_cfg,
   output logic       o_busy,
   output logic       o_done
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic field_on(input word_t w, input int lsb);
      field_on = (w[lsb +: 2] == FIELD_ON);
   endfunction : field_on

   typedef enum logic [1:0] {L_START, L_ISSUE, L_WAIT, L_DONE} load_e;

   localparam cfg_s CFG_RST = '{mac: RST_MAC, vendor_id: DEF_VENDOR_ID,
      product_id: DEF_PRODUCT_ID, pin: RST_PIN, phy: RST_PHY, misc: RST_MISC,
      sw_ctl: RST_BYTE, vlan_ctl: RST_BYTE, port: '0, prio_lo: RST_BYTE,
      prio_hi: RST_BYTE};

   // ----------------------------------------------------------------
   // word fetcher
   // ----------------------------------------------------------------
   load_e state_r, state_nxt;
   addr_t addr_r,  addr_nxt;
   word_t auto_r,  auto_nxt;
   word_t grp_r,   grp_nxt;
   cfg_s  cfg_r,   cfg_nxt;
   logic  busy_r,  busy_nxt;
   logic  done_r,  done_nxt;
   logic  fetch_done;
   word_t fetch_data;
   logic  word_ok;

   eeprom_word_fetch eeprom_word_fetch_i (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_start    (state_r == L_ISSUE),
      .i_addr     (addr_r),
      .o_done     (fetch_done),
      .o_data     (fetch_data),
      .o_mem_req  (o_mem_req),
      .o_mem_addr (o_mem_addr),
      .i_mem_ack  (i_mem_ack),
      .i_mem_data (i_mem_data)
   );

   assign word_ok = (state_r == L_WAIT) && fetch_done;

   // ----------------------------------------------------------------
   // enable decode from the two control words
   // ----------------------------------------------------------------
   logic  en_id, en_pin, en_wake, en_misc, en_led, en_mdix;
   logic  en_sw, en_port, en_tag, en_prio;
   logic [5:0] port_idx;
   logic [5:0] tag_idx;

   // every field other than 01 disables its group
   always_comb begin
      en_id    = field_on(auto_r, AC_ID_LSB);     // R2 R25
      en_pin   = field_on(auto_r, AC_PIN_LSB);    // R3
      en_wake  = field_on(auto_r, AC_WAKE_LSB);   // R4
      en_misc  = field_on(auto_r, AC_MISC_LSB);   // R5
      en_led   = field_on(auto_r, AC_LED_LSB);    // R4
      en_mdix  = field_on(auto_r, AC_MDIX_LSB);   // R4
      en_sw    = field_on(grp_r, GC_SW_LSB);      // R16
      en_port  = field_on(grp_r, GC_PORT_LSB);    // R16
      en_tag   = field_on(grp_r, GC_TAG_LSB);     // R16
      en_prio  = field_on(grp_r, GC_PRIO_LSB);    // R16
      port_idx = addr_r - W_PORT_FIRST;
      tag_idx  = addr_r - W_TAG_FIRST;
   end

   // ----------------------------------------------------------------
   // load sequence and word application
   // ----------------------------------------------------------------
   // words 9..15 are reserved and skipped; a group word is still read
   // when disabled so the walk length never depends on memory content
   always_comb begin
      state_nxt = state_r;
      addr_nxt  = addr_r;
      auto_nxt  = auto_r;
      grp_nxt   = grp_r;
      cfg_nxt   = cfg_r;
      busy_nxt  = busy_r;
      done_nxt  = done_r;
      case (state_r)
         L_START: begin
            state_nxt = L_ISSUE;
            busy_nxt  = 1'b1;
         end
         L_ISSUE: begin
            state_nxt = L_WAIT;
         end
         L_WAIT: begin
            if (fetch_done) begin
               if (addr_r <= W_MAC_LAST) begin
                  cfg_nxt.mac[{addr_r[1:0], 4'h0} +: 16] = fetch_data;      // R1
               end
               if (addr_r == W_AUTO_CTL) begin
                  auto_nxt = fetch_data;
               end
               if (addr_r == W_VENDOR && en_id) begin
                  cfg_nxt.vendor_id = fetch_data;                           // R6
               end
               if (addr_r == W_PRODUCT && en_id) begin
                  cfg_nxt.product_id = fetch_data;                          // R6
               end
               if (addr_r == W_PIN_CTL && en_pin) begin
                  cfg_nxt.pin = fetch_data[4:0];                            // R7 R8 R9
               end
               if (addr_r == W_PHY_CTL) begin
                  if (en_wake) begin
                     cfg_nxt.phy.wake = fetch_data[3:0];                    // R10 R11 R12
                  end
                  if (en_led) begin
                     cfg_nxt.phy.led_alt = fetch_data[8];                   // R13
                  end
                  if (en_mdix) begin
                     cfg_nxt.phy.mdix_p1 = fetch_data[14];                  // R15
                     cfg_nxt.phy.mdix_p0 = fetch_data[15];                  // R15
                  end
               end
               if (addr_r == W_MISC && en_misc) begin
                  cfg_nxt.misc = fetch_data[4:0];                           // R5
               end
               if (addr_r == W_GRP_CTL) begin
                  grp_nxt = fetch_data;
               end
               if (addr_r == W_SWITCH && en_sw) begin
                  cfg_nxt.sw_ctl   = fetch_data[7:0];                       // R18
                  cfg_nxt.vlan_ctl = fetch_data[15:8];                      // R18
               end
               if (addr_r >= W_PORT_FIRST && addr_r <= W_PORT_LAST && en_port) begin
                  if (!port_idx[0]) begin
                     cfg_nxt.port[port_idx[2:1]].ctl_61 = fetch_data[7:0];  // R20
                     cfg_nxt.port[port_idx[2:1]].ctl_66 = fetch_data[15:8]; // R20
                  end else begin
                     cfg_nxt.port[port_idx[2:1]].ctl_67 = fetch_data[7:0];  // R21
                     cfg_nxt.port[port_idx[2:1]].ctl_6d = fetch_data[15:8]; // R21
                  end
               end
               if (addr_r >= W_TAG_FIRST && addr_r <= W_TAG_LAST && en_tag) begin
                  cfg_nxt.port[tag_idx[1:0]].tag_6e = fetch_data[7:0];      // R22 R23
                  cfg_nxt.port[tag_idx[1:0]].tag_6f = fetch_data[15:8];     // R22 R23
               end
               if (addr_r == W_PRIO && en_prio) begin
                  cfg_nxt.prio_lo = fetch_data[7:0];                        // R24
                  cfg_nxt.prio_hi = fetch_data[15:8];                       // R24
               end
               if (addr_r == W_PRIO) begin
                  state_nxt = L_DONE;
                  busy_nxt  = 1'b0;
                  done_nxt  = 1'b1;
               end else begin
                  state_nxt = L_ISSUE;
                  addr_nxt  = (addr_r == W_MISC) ? W_GRP_CTL : addr_r + 6'h01;
               end
            end
         end
         L_DONE: begin
            state_nxt = L_DONE;
         end
         default: begin
            state_nxt = L_START;
         end
      endcase
   end

   // registers only; defaults stand until an enabled word arrives
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= L_START;
         addr_r  <= W_MAC_FIRST;
         auto_r  <= 16'h0000;
         grp_r   <= 16'h0000;
         cfg_r   <= CFG_RST;                                                // R25
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r  <= addr_nxt;
         auto_r  <= auto_nxt;
         grp_r   <= grp_nxt;
         cfg_r   <= cfg_nxt;
         busy_r  <= busy_nxt;
         done_r  <= done_nxt;
      end
   end

   assign o_cfg  = cfg_r;
   assign o_busy = busy_r;
   assign o_done = done_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // gated words: a disabled field must leave the previous value standing
   a_mac_word_load: assert property (word_ok && addr_r == 6'h01 |=> cfg_r.mac[31:16] == $past(fetch_data)) // R1
      else $error("mac word 1 not loaded");
   a_id_gate: assert property (word_ok && addr_r == W_VENDOR |=> // R2
      cfg_r.vendor_id == ($past(en_id) ? $past(fetch_data) : $past(cfg_r.vendor_id)))
      else $error("vendor code gating wrong");
   a_pin_gate: assert property (word_ok && addr_r == W_PIN_CTL |=> // R3
      cfg_r.pin == ($past(en_pin) ? $past(fetch_data[4:0]) : $past(cfg_r.pin)))
      else $error("pin control gating wrong");
   a_led_gate: assert property (word_ok && addr_r == W_PHY_CTL |=> // R4
      cfg_r.phy.led_alt == ($past(en_led) ? $past(fetch_data[8]) : $past(cfg_r.phy.led_alt)))
      else $error("led mode gating wrong");
   a_mdix_hold: assert property (word_ok && addr_r == W_PHY_CTL && !en_mdix |=> // R15
      cfg_r.phy.mdix_p0 == $past(cfg_r.phy.mdix_p0) && cfg_r.phy.mdix_p1 == $past(cfg_r.phy.mdix_p1))
      else $error("crossover changed while disabled");
   a_misc_gate: assert property (word_ok && addr_r == W_MISC && en_misc |=> // R5
      cfg_r.misc == $past(fetch_data[4:0]))
      else $error("word 8 setting not loaded");
   a_switch_load: assert property (word_ok && addr_r == W_SWITCH && en_sw |=> // R18
      {cfg_r.vlan_ctl, cfg_r.sw_ctl} == $past(fetch_data))
      else $error("switch control not loaded");
   a_port_word: assert property (word_ok && addr_r == 6'h15 && en_port |=> // R20
      {cfg_r.port[1].ctl_66, cfg_r.port[1].ctl_61} == $past(fetch_data))
      else $error("port 1 control not loaded");
   a_uptag_load: assert property (word_ok && addr_r == W_TAG_LAST && en_tag |=> // R23
      {cfg_r.port[3].tag_6f, cfg_r.port[3].tag_6e} == $past(fetch_data))
      else $error("processor port tag not loaded");
   a_prio_hold: assert property (word_ok && addr_r == W_PRIO && !en_prio |=> // R25
      $stable(cfg_r.prio_lo) ##0 $stable(cfg_r.prio_hi))
      else $error("priority map changed while disabled");
   a_skip_reserved: assert property (word_ok && addr_r == W_MISC |=> // R16
      addr_r == W_GRP_CTL ##1 o_mem_addr == W_GRP_CTL)
      else $error("reserved words not skipped");
   a_done_end: assert property ($rose(done_r) |-> $past(addr_r) == W_PRIO && !busy_r) // R24
      else $error("load ended at wrong word");
   a_wake_gate: assert property (word_ok && addr_r == W_PHY_CTL |=> // R4
      cfg_r.phy.wake == ($past(en_wake) ? $past(fetch_data[3:0]) : $past(cfg_r.phy.wake)))
      else $error("wake settings gating wrong");
   a_mdix_load: assert property (word_ok && addr_r == W_PHY_CTL && en_mdix |=> // R15
      {cfg_r.phy.mdix_p0, cfg_r.phy.mdix_p1} == $past(fetch_data[15:14]))
      else $error("crossover bits not loaded");
   a_product_gate: assert property (word_ok && addr_r == W_PRODUCT |=> // R6
      cfg_r.product_id == ($past(en_id) ? $past(fetch_data) : $past(cfg_r.product_id)))
      else $error("product code gating wrong");
   a_tag_load: assert property (word_ok && addr_r == W_TAG_FIRST && en_tag |=> // R22
      {cfg_r.port[0].tag_6f, cfg_r.port[0].tag_6e} == $past(fetch_data))
      else $error("port 0 tag not loaded");
   a_port_last: assert property (word_ok && addr_r == W_PORT_LAST && en_port |=> // R21
      {cfg_r.port[3].ctl_6d, cfg_r.port[3].ctl_67} == $past(fetch_data))
      else $error("processor port control not loaded");
   a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)) // R16
      else $error("memory request dropped early");

   c_load_done:  cover property ($rose(done_r));
   c_tag_group:  cover property (word_ok && addr_r == W_TAG_LAST && en_tag);
   c_port_group: cover property (word_ok && addr_r == W_PORT_LAST && en_port);
   c_mdix_off:   cover property (word_ok && addr_r == W_PHY_CTL && en_mdix && fetch_data[15:14] == 2'h0);

endmodule : eeprom_autoload_config
`default_nettype wire

// file: eeprom_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_mem_model
   import eeprom_autoload_pkg::*;
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // word port from the loader
   input  wire logic       i_req,
   input  wire addr_t      i_addr,
   output logic            o_ack,
   output word_t           o_data,
   // memory image and answer speed
   input  wire word_t      i_image [0:63],
   input  wire logic [3:0] i_delay
);
   logic [3:0] wait_r;

   // -------------------------------------------------------------
   // answer path
   // -------------------------------------------------------------
   // one-cycle ack after i_delay waiting cycles; data toggles outside the
   // ack cycle so a loader sampling at the wrong edge picks up garbage
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack  <= 1'b0;
         wait_r <= 4'h0;
         o_data <= 16'h0000;
      end else if (o_ack) begin
         o_ack  <= 1'b0;
         wait_r <= 4'h0;
         o_data <= ~o_data;
      end else if (i_req && wait_r >= i_delay) begin
         o_ack  <= 1'b1;
         o_data <= i_image[i_addr];
      end else begin
         wait_r <= i_req ? wait_r + 4'h1 : 4'h0;
         o_data <= ~o_data;
      end
   end
endmodule : eeprom_mem_model
`default_nettype wire

// file: eeprom_autoload_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_autoload_config_tb;
   import eeprom_autoload_pkg::*;
   localparam logic [15:0] VID = 16'h1234; // arbitrary value
   localparam logic [15:0] PID = 16'h5678; // arbitrary value

   logic       i_clk;
   logic       i_rst;
   logic       mem_req;
   logic       mem_ack;
   logic       busy;
   logic       done;
   addr_t      mem_addr;
   word_t      mem_data;
   cfg_s       cfg;
   word_t      img [0:63];
   logic [3:0] delay;
   int         failures;
   int         checks_done;
   int         idx;

   eeprom_autoload_config #(.DEF_VENDOR_ID(VID), .DEF_PRODUCT_ID(PID)) eeprom_autoload_config_i (
      .i_clk(i_clk), .i_rst(i_rst), .o_mem_req(mem_req), .o_mem_addr(mem_addr),
      .i_mem_ack(mem_ack), .i_mem_data(mem_data), .o_cfg(cfg), .o_busy(busy), .o_done(done));

   eeprom_mem_model eeprom_mem_model_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(mem_req), .i_addr(mem_addr), .o_ack(mem_ack),
      .o_data(mem_data), .i_image(img), .i_delay(delay));

   // -------------------------------------------------------------
   // clock and helpers
   // -------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task automatic check(input logic [191:0] seen, input logic [191:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   function automatic logic gate_on(input word_t w, input int lsb);
      return w[lsb+:2] === FIELD_ON;
   endfunction : gate_on

   // expected settings from the image; disabled groups keep reset values
   function automatic cfg_s build_exp();
      cfg_s e;
      e = '0;
      e.mac = {img[2], img[1], img[0]};
      e.vendor_id = gate_on(img[3], AC_ID_LSB) ? img[4] : VID;
      e.product_id = gate_on(img[3], AC_ID_LSB) ? img[5] : PID;
      e.pin = gate_on(img[3], AC_PIN_LSB) ? img[6][4:0] : RST_PIN;
      e.phy = RST_PHY;
      if (gate_on(img[3], AC_WAKE_LSB)) e.phy.wake = img[7][3:0];
      if (gate_on(img[3], AC_LED_LSB)) e.phy.led_alt = img[7][8];
      if (gate_on(img[3], AC_MDIX_LSB)) {e.phy.mdix_p0, e.phy.mdix_p1} = img[7][15:14];
      e.misc = gate_on(img[3], AC_MISC_LSB) ? img[8][4:0] : RST_MISC;
      if (gate_on(img[16], GC_SW_LSB)) {e.vlan_ctl, e.sw_ctl} = img[17];
      for (int p = 0; p < 4; p++) begin
         if (gate_on(img[16], GC_PORT_LSB)) begin
            {e.port[p].ctl_66, e.port[p].ctl_61} = img[19 + 2 * p];
            {e.port[p].ctl_6d, e.port[p].ctl_67} = img[20 + 2 * p];
         end
         if (gate_on(img[16], GC_TAG_LSB)) {e.port[p].tag_6f, e.port[p].tag_6e} = img[27 + p];
      end
      if (gate_on(img[16], GC_PRIO_LSB)) {e.prio_hi, e.prio_lo} = img[31];
      return e;
   endfunction : build_exp

   // -------------------------------------------------------------
   // request monitor: words 0..8 then 16..31, once each
   // -------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_rst) begin
         idx = 0;
      end else if (mem_req && mem_ack) begin
         check(192'(mem_addr), 192'(idx < 9 ? idx : idx + 7));
         idx++;
      end
   end

   // -------------------------------------------------------------
   // one load: image, reset, optional mid-load reset, compare
   // -------------------------------------------------------------
   task automatic run(input word_t w3, input word_t w16, input logic [3:0] dly, input bit abort);
      cfg_s e;
      int   n;
      for (int k = 0; k < 64; k++) img[k] = {8'(k) ^ 8'hA5, 8'(k) ^ 8'h3C};
      img[3] = w3;
      img[16] = w16 & 16'h3FFF;
      img[6] = 16'hFFF5; // reserved upper bits set: must be dropped
      // bit 15 of w16 is masked off above, so it picks a crossover-off image
      img[7] = w16[15] ? 16'h010B : 16'h410B;
      img[8] = 16'h0013;
      img[18] = 16'h0000;
      delay = dly;
      i_rst = 1'b1;
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (2) @(negedge i_clk);
      check(192'({busy, done}), 192'(2));
      if (abort) begin
         repeat (40) @(negedge i_clk);
         i_rst = 1'b1;
         @(negedge i_clk);
         check(192'({mem_req, busy, done}), 192'(0));
         check(192'(cfg.phy), 192'(RST_PHY));
         i_rst = 1'b0;
      end
      e = build_exp();
      n = 0;
      while (done !== 1'b1 && n < 1000) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 1000) begin
         failures++;
         end_sim();
      end
      check(192'(cfg.mac), 192'(e.mac));
      check(192'({cfg.vendor_id, cfg.product_id}), 192'({e.vendor_id, e.product_id}));
      check(192'(cfg.pin), 192'(e.pin));
      check(192'(cfg.phy), 192'(e.phy));
      check(192'(cfg.misc), 192'(e.misc));
      check(192'({cfg.vlan_ctl, cfg.sw_ctl}), 192'({e.vlan_ctl, e.sw_ctl}));
      check(192'(cfg.port), 192'(e.port));
      check(192'({cfg.prio_hi, cfg.prio_lo}), 192'({e.prio_hi, e.prio_lo}));
      repeat (8) @(negedge i_clk);
      check(192'({mem_req, busy, done}), 192'(1));
      check(192'(idx), 192'(25));
   endtask : run

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      i_rst = 1'b1;
      delay = 4'h0;
      failures = 0;
      checks_done = 0;
      run(16'h4545, 16'h0055, 4'h3, 1'b0); // every group on, slow memory
      run(16'hAAAA, 16'h2AAA, 4'h0, 1'b0); // every field 10, prompt memory
      run(16'hC50D, 16'h0047, 4'h1, 1'b1); // mixed fields, reset mid-load
      run(16'hFFFF, 16'h3FFF, 4'h2, 1'b0); // every field 11
      run(16'h4000, 16'h8001, 4'h0, 1'b0); // crossover on with both bits 0, switch group only
      end_sim();
   end
endmodule : eeprom_autoload_config_tb
`default_nettype wire
